// >>> smaf_defs.svh
// constants for the secure memory access filter: offsets, field positions, reset values
// assumes inclusion by every design file that needs them; definitions only
// Function
// - each cache line keeps its security attribute
// - non-secure read hit on secure line is miss; a write still updates the line
// - such read misses fill, pass errors, never allocate
// - control register takes secure writes only
// - auxiliary register takes secure writes only; bit 26 gates lockdown
// - non-secure maintenance spares secure lines
// - non-secure debug register access gets DECERR
// - memory split into 64 MB sections, one bit each; only the lowest 32 (SECT_COUNT) have a bit, the rest are secure only
// - section bit zero means secure only
// - section bit one means non-secure region
// - secure reaches all; non-secure only non-secure
// - non-secure access to secure section gets DECERR
// - blocked writes reach memory fully masked
// - blocked reads return all zero data
// - all section bits reset to zero
`ifndef SMAF_DEFS_SVH
`define SMAF_DEFS_SVH

`define SMAF_SECT_SHIFT      26
`define SMAF_SECT_RESET      32'h0000_0000
`define SMAF_RESP_OKAY       2'h0
`define SMAF_RESP_DECERR     2'h3
`define SMAF_CFG_SEL_LSB     2
`define SMAF_CFG_CTRL        2'h0
`define SMAF_CFG_AUX         2'h1
`define SMAF_CFG_LOCK        2'h2
`define SMAF_CFG_DEBUG       2'h3
`define SMAF_CTRL_EN_BIT     0
`define SMAF_AUX_NS_LOCK_BIT 26
`define SMAF_CTRL_RESET      32'h0000_0000
`define SMAF_AUX_RESET       32'h0000_0000
`define SMAF_LOCK_RESET      32'h0000_0000
`define SMAF_DEBUG_RESET     32'h0000_0000
`define SMAF_STRB_ALL        4'hf
`define SMAF_STRB_NONE       4'h0

`endif

// >>> smaf_pkg.sv
// types shared by the secure memory access filter
// assumes nothing of its surroundings
`default_nettype none

package smaf_pkg;

    typedef logic [31:0] smaf_word_type;
    typedef logic [1:0]  smaf_resp_type;

    typedef enum logic [2:0] {
        SMAF_OP_READ,
        SMAF_OP_WRITE,
        SMAF_OP_INV,
        SMAF_OP_INV_ALL,
        SMAF_OP_CFG_RD,
        SMAF_OP_CFG_WR
    } smaf_op_type;

    typedef struct packed {
        logic          valid;
        smaf_op_type   op;
        logic          ns;
        smaf_word_type addr;
        smaf_word_type wdata;
    } smaf_up_req_type;

    typedef struct packed {
        logic          valid;
        smaf_resp_type resp;
        smaf_word_type rdata;
    } smaf_up_rsp_type;

    typedef struct packed {
        logic          valid;
        logic          write;
        logic          ns;
        smaf_word_type addr;
        smaf_word_type wdata;
        logic [3:0]    wstrb;
    } smaf_mem_req_type;

    typedef struct packed {
        logic          valid;
        smaf_resp_type resp;
        smaf_word_type rdata;
    } smaf_mem_rsp_type;

endpackage

`default_nettype wire

// >>> smaf_section_lookup.sv
// section security lookup for one access
// assumes the section bits come from a register in the caller
`include "smaf_defs.svh"
`default_nettype none

module smaf_section_lookup #(
    parameter int SECT_COUNT = 32
) (
    input  wire logic [SECT_COUNT-1:0] sect_ns,
    input  wire smaf_pkg::smaf_word_type addr,
    input  wire logic                  ns,
    output logic                       deny
);
    import smaf_pkg::*;

    smaf_word_type sect_index;
    logic          sect_open;

    always_comb begin
        sect_index = addr >> `SMAF_SECT_SHIFT;
        sect_open  = 1'b0;
        if (sect_index < SECT_COUNT) begin
            sect_open = sect_ns[sect_index];
        end
        deny = ns && !sect_open;
    end

endmodule

`default_nettype wire

// >>> smaf_cfg_regs.sv
// cache configuration registers with security-checked access
// assumes one access pulse at a time from the cache controller
`include "smaf_defs.svh"
`default_nettype none

module smaf_cfg_regs (
    input  wire logic                    clk,
    input  wire logic                    rst,
    input  wire logic                    acc_valid,
    input  wire logic                    acc_write,
    input  wire logic                    acc_ns,
    input  wire logic [1:0]              acc_sel,
    input  wire smaf_pkg::smaf_word_type acc_wdata,
    output smaf_pkg::smaf_word_type      rd_data,
    output smaf_pkg::smaf_resp_type      rd_resp,
    output logic                         cache_en,
    output logic                         ns_lock_en
);
    import smaf_pkg::*;

    smaf_word_type ctrl;
    smaf_word_type aux;
    smaf_word_type lock;
    smaf_word_type debug;
    smaf_word_type next_ctrl;
    smaf_word_type next_aux;
    smaf_word_type next_lock;
    smaf_word_type next_debug;
    logic          wr;

    always_comb begin
        wr         = acc_valid && acc_write;
        next_ctrl  = ctrl;
        next_aux   = aux;
        next_lock  = lock;
        next_debug = debug;
        rd_resp    = `SMAF_RESP_OKAY;
        rd_data    = '0;
        unique case (acc_sel)
            `SMAF_CFG_CTRL: begin
                rd_data = ctrl;
                if (wr && !acc_ns) begin
                    next_ctrl = acc_wdata;
                end
            end
            `SMAF_CFG_AUX: begin
                rd_data = aux;
                if (wr && !acc_ns) begin
                    next_aux = acc_wdata;
                end
            end
            `SMAF_CFG_LOCK: begin
                rd_data = lock;
                if (wr && (!acc_ns || aux[`SMAF_AUX_NS_LOCK_BIT])) begin
                    next_lock = acc_wdata;
                end
            end
            `SMAF_CFG_DEBUG: begin
                if (acc_ns) begin
                    rd_resp = `SMAF_RESP_DECERR;
                end else begin
                    rd_data = debug;
                    if (wr) begin
                        next_debug = acc_wdata;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl  <= `SMAF_CTRL_RESET;
            aux   <= `SMAF_AUX_RESET;
            lock  <= `SMAF_LOCK_RESET;
            debug <= `SMAF_DEBUG_RESET;
        end else begin
            ctrl  <= next_ctrl;
            aux   <= next_aux;
            lock  <= next_lock;
            debug <= next_debug;
        end
    end

    assign cache_en   = ctrl[`SMAF_CTRL_EN_BIT];
    assign ns_lock_en = aux[`SMAF_AUX_NS_LOCK_BIT];

endmodule

`default_nettype wire

// >>> smaf_top.sv
// security-tagged cache and section filter on the path to external memory
// assumes one outstanding upstream request and a memory that answers each request once
`include "smaf_defs.svh"
`default_nettype none

module smaf_top #(
    parameter int LINES      = 16,
    parameter int SECT_COUNT = 32
) (
    input  wire logic                      clk,
    input  wire logic                      rst,
    input  wire smaf_pkg::smaf_up_req_type up_req,
    output logic                           up_ready,
    output smaf_pkg::smaf_up_rsp_type      up_rsp,
    output smaf_pkg::smaf_mem_req_type     mem_req,
    input  wire logic                      mem_ready,
    input  wire smaf_pkg::smaf_mem_rsp_type mem_rsp,
    input  wire logic                      sect_load,
    input  wire logic [SECT_COUNT-1:0]     sect_value,
    output logic                           cache_enabled,
    output logic                           ns_lockdown_enabled
);
    import smaf_pkg::*;

    localparam int IDX_W = $clog2(LINES);
    localparam int TAG_W = 30 - IDX_W;

    typedef enum {
        ST_IDLE,
        ST_MEM_REQ,
        ST_MEM_RSP
    } smaf_state_type;

    smaf_state_type   state;
    smaf_state_type   next_state;
    smaf_up_req_type  cur;
    smaf_up_req_type  next_cur;
    logic             cur_deny;
    logic             next_cur_deny;
    logic             cur_alloc;
    logic             next_cur_alloc;
    logic             next_up_ready;
    smaf_up_rsp_type  next_up_rsp;
    smaf_mem_req_type next_mem_req;
    logic [SECT_COUNT-1:0] sect_ns;
    logic [SECT_COUNT-1:0] next_sect_ns;

    logic             line_valid [LINES];
    logic             line_ns    [LINES];
    logic [TAG_W-1:0] line_tag   [LINES];
    smaf_word_type    line_data  [LINES];
    logic             next_line_valid [LINES];
    logic             next_line_ns    [LINES];
    logic [TAG_W-1:0] next_line_tag   [LINES];
    smaf_word_type    next_line_data  [LINES];

    logic             take;
    logic [IDX_W-1:0] req_idx;
    logic [TAG_W-1:0] req_tag;
    logic [IDX_W-1:0] cur_idx;
    logic [TAG_W-1:0] cur_tag;
    logic             tag_match;
    logic             hit;
    logic             secure_clash;
    logic             req_deny;
    logic             cache_en;
    logic             ns_lock_en;
    logic             cfg_valid;
    smaf_word_type    cfg_rdata;
    smaf_resp_type    cfg_resp;

    smaf_section_lookup #(
        .SECT_COUNT (SECT_COUNT)
    ) u_lookup (
        .sect_ns (sect_ns),
        .addr    (up_req.addr),
        .ns      (up_req.ns),
        .deny    (req_deny)
    );

    smaf_cfg_regs u_cfg (
        .clk        (clk),
        .rst        (rst),
        .acc_valid  (cfg_valid),
        .acc_write  (up_req.op == SMAF_OP_CFG_WR),
        .acc_ns     (up_req.ns),
        .acc_sel    (up_req.addr[`SMAF_CFG_SEL_LSB +: 2]),
        .acc_wdata  (up_req.wdata),
        .rd_data    (cfg_rdata),
        .rd_resp    (cfg_resp),
        .cache_en   (cache_en),
        .ns_lock_en (ns_lock_en)
    );

    // lookup of the incoming request
    always_comb begin
        take         = up_req.valid && up_ready;
        req_idx      = up_req.addr[IDX_W+1:2];
        req_tag      = up_req.addr[31:IDX_W+2];
        cur_idx      = cur.addr[IDX_W+1:2];
        cur_tag      = cur.addr[31:IDX_W+2];
        tag_match    = line_valid[req_idx] && (line_tag[req_idx] == req_tag);
        hit          = cache_en && tag_match && (line_ns[req_idx] == up_req.ns);
        secure_clash = tag_match && up_req.ns && !line_ns[req_idx];
        cfg_valid    = take && (up_req.op == SMAF_OP_CFG_RD || up_req.op == SMAF_OP_CFG_WR);
    end

    // section control bits
    always_comb begin
        next_sect_ns = sect_ns;
        if (sect_load) begin
            next_sect_ns = sect_value;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sect_ns <= SECT_COUNT'(`SMAF_SECT_RESET);
        end else begin
            sect_ns <= next_sect_ns;
        end
    end

    // request sequencing and cache lines
    always_comb begin
        next_state     = state;
        next_cur       = cur;
        next_cur_deny  = cur_deny;
        next_cur_alloc = cur_alloc;
        next_up_ready  = up_ready;
        next_up_rsp    = '0;
        next_mem_req   = mem_req;
        for (int i = 0; i < LINES; i++) begin
            next_line_valid[i] = line_valid[i];
            next_line_ns[i]    = line_ns[i];
            next_line_tag[i]   = line_tag[i];
            next_line_data[i]  = line_data[i];
        end
        unique case (state)
            ST_IDLE: begin
                next_up_ready = 1'b1;
                if (take) begin
                    next_up_ready = 1'b0;
                    next_cur      = up_req;
                    next_cur_deny = req_deny;
                    unique case (up_req.op)
                        SMAF_OP_READ: begin
                            if (req_deny) begin
                                next_up_rsp.valid = 1'b1;
                                next_up_rsp.resp  = `SMAF_RESP_DECERR;
                                next_up_rsp.rdata = '0;
                            end else if (hit) begin
                                next_up_rsp.valid = 1'b1;
                                next_up_rsp.resp  = `SMAF_RESP_OKAY;
                                next_up_rsp.rdata = line_data[req_idx];
                            end else begin
                                next_mem_req.valid = 1'b1;
                                next_mem_req.write = 1'b0;
                                next_mem_req.ns    = up_req.ns;
                                next_mem_req.addr  = up_req.addr;
                                next_mem_req.wdata = '0;
                                next_mem_req.wstrb = `SMAF_STRB_NONE;
                                next_cur_alloc     = cache_en && !secure_clash;
                                next_state         = ST_MEM_REQ;
                            end
                        end
                        SMAF_OP_WRITE: begin
                            if (tag_match && !req_deny) begin
                                next_line_data[req_idx] = up_req.wdata;
                            end
                            next_mem_req.valid = 1'b1;
                            next_mem_req.write = 1'b1;
                            next_mem_req.ns    = up_req.ns;
                            next_mem_req.addr  = up_req.addr;
                            next_mem_req.wdata = req_deny ? '0 : up_req.wdata;
                            next_mem_req.wstrb = req_deny ? `SMAF_STRB_NONE : `SMAF_STRB_ALL;
                            next_cur_alloc     = 1'b0;
                            next_state         = ST_MEM_REQ;
                        end
                        SMAF_OP_INV: begin
                            if (tag_match && !secure_clash) begin
                                next_line_valid[req_idx] = 1'b0;
                            end
                            next_up_rsp.valid = 1'b1;
                            next_up_rsp.resp  = `SMAF_RESP_OKAY;
                        end
                        SMAF_OP_INV_ALL: begin
                            for (int i = 0; i < LINES; i++) begin
                                if (!(up_req.ns && !line_ns[i])) begin
                                    next_line_valid[i] = 1'b0;
                                end
                            end
                            next_up_rsp.valid = 1'b1;
                            next_up_rsp.resp  = `SMAF_RESP_OKAY;
                        end
                        SMAF_OP_CFG_RD,
                        SMAF_OP_CFG_WR: begin
                            next_up_rsp.valid = 1'b1;
                            next_up_rsp.resp  = cfg_resp;
                            next_up_rsp.rdata = (up_req.op == SMAF_OP_CFG_RD) ? cfg_rdata : '0;
                        end
                        default: begin
                            next_up_rsp.valid = 1'b1;
                            next_up_rsp.resp  = `SMAF_RESP_DECERR;
                        end
                    endcase
                end
            end
            ST_MEM_REQ: begin
                if (mem_ready) begin
                    next_mem_req.valid = 1'b0;
                    next_state         = ST_MEM_RSP;
                end
            end
            ST_MEM_RSP: begin
                if (mem_rsp.valid) begin
                    next_up_rsp.valid = 1'b1;
                    next_up_rsp.resp  = cur_deny ? `SMAF_RESP_DECERR : mem_rsp.resp;
                    next_up_rsp.rdata = (cur_deny || cur.op == SMAF_OP_WRITE) ? '0
                                                                               : mem_rsp.rdata;
                    if (cur_alloc && mem_rsp.resp == `SMAF_RESP_OKAY) begin
                        next_line_valid[cur_idx] = 1'b1;
                        next_line_ns[cur_idx]    = cur.ns;
                        next_line_tag[cur_idx]   = cur_tag;
                        next_line_data[cur_idx]  = mem_rsp.rdata;
                    end
                    next_up_ready = 1'b1;
                    next_state    = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state     <= ST_IDLE;
            cur       <= '0;
            cur_deny  <= 1'b0;
            cur_alloc <= 1'b0;
            up_ready  <= 1'b0;
            up_rsp    <= '0;
            mem_req   <= '0;
            for (int i = 0; i < LINES; i++) begin
                line_valid[i] <= 1'b0;
                line_ns[i]    <= 1'b0;
                line_tag[i]   <= '0;
                line_data[i]  <= '0;
            end
        end else begin
            state     <= next_state;
            cur       <= next_cur;
            cur_deny  <= next_cur_deny;
            cur_alloc <= next_cur_alloc;
            up_ready  <= next_up_ready;
            up_rsp    <= next_up_rsp;
            mem_req   <= next_mem_req;
            for (int i = 0; i < LINES; i++) begin
                line_valid[i] <= next_line_valid[i];
                line_ns[i]    <= next_line_ns[i];
                line_tag[i]   <= next_line_tag[i];
                line_data[i]  <= next_line_data[i];
            end
        end
    end

    // status flags, copies of the configuration bits
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cache_enabled       <= 1'b0;
            ns_lockdown_enabled <= 1'b0;
        end else begin
            cache_enabled       <= cache_en;
            ns_lockdown_enabled <= ns_lock_en;
        end
    end

endmodule

`default_nettype wire

// >>> smaf_top_sva.sv
// port assertions for the filter
// assumes binding to smaf_top
`include "smaf_defs.svh"
`default_nettype none

module smaf_top_chk #(
    parameter int LINES      = 16,
    parameter int SECT_COUNT = 32
) (
    input wire logic                       clk,
    input wire logic                       rst,
    input wire smaf_pkg::smaf_up_req_type  up_req,
    input wire logic                       up_ready,
    input wire smaf_pkg::smaf_up_rsp_type  up_rsp,
    input wire smaf_pkg::smaf_mem_req_type mem_req,
    input wire logic                       mem_ready,
    input wire smaf_pkg::smaf_mem_rsp_type mem_rsp,
    input wire logic                       sect_load,
    input wire logic [SECT_COUNT-1:0]      sect_value,
    input wire logic                       cache_enabled,
    input wire logic                       ns_lockdown_enabled
);
    import smaf_pkg::*;
    logic [SECT_COUNT-1:0] sect;
    logic                  mem_wr;
    logic                  take;
    logic                  cw;
    logic [1:0]            sel;
    assign take = up_req.valid && up_ready;
    assign cw = take && up_req.op == SMAF_OP_CFG_WR;
    assign sel = up_req.addr[3:2];
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sect <= '0;
            mem_wr <= 1'b0;
        end else begin
            if (sect_load) sect <= sect_value;
            if (mem_req.valid && mem_ready) mem_wr <= mem_req.write;
        end
    end
    function automatic logic blk(logic n, smaf_word_type a);
        return n && ((32'(a[31:26]) >= SECT_COUNT) || !sect[a[31:26]]);
    endfunction
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    property p_deny_rd;
        take && up_req.op == SMAF_OP_READ && blk(up_req.ns, up_req.addr)
            |=> up_rsp == {1'b1, `SMAF_RESP_DECERR, 32'h0} && !mem_req.valid;
    endproperty
    a_deny_rd: assert property (p_deny_rd) else $error("deny read");
    property p_deny_wr;
        mem_req.valid && mem_req.write && blk(mem_req.ns, mem_req.addr)
            |-> mem_req.wstrb == `SMAF_STRB_NONE && mem_req.wdata == 32'h0;
    endproperty
    a_deny_wr: assert property (p_deny_wr) else $error("deny write");
    property p_hold;
        mem_req.valid && !mem_ready |=> $stable(mem_req);
    endproperty
    a_hold: assert property (p_hold) else $error("mem hold");
    property p_pass;
        mem_rsp.valid && !mem_wr |=> up_rsp.valid && up_rsp.resp == $past(mem_rsp.resp);
    endproperty
    a_pass: assert property (p_pass) else $error("mem error lost");
    property p_dbg;
        (cw || take && up_req.op == SMAF_OP_CFG_RD) && up_req.ns && sel == `SMAF_CFG_DEBUG
            |=> up_rsp.valid && up_rsp.resp == `SMAF_RESP_DECERR;
    endproperty
    a_dbg: assert property (p_dbg) else $error("debug open");
    property p_ctrl_ns;
        cw && up_req.ns && sel == `SMAF_CFG_CTRL |-> ##1 ($stable(cache_enabled))[*3];
    endproperty
    a_ctrl_ns: assert property (p_ctrl_ns) else $error("ctrl ns write");
    property p_aux_ns;
        cw && up_req.ns && sel == `SMAF_CFG_AUX |-> ##1 ($stable(ns_lockdown_enabled))[*3];
    endproperty
    a_aux_ns: assert property (p_aux_ns) else $error("aux ns write");
    property p_ctrl_s;
        cw && !up_req.ns && sel == `SMAF_CFG_CTRL
            |-> ##2 cache_enabled == $past(up_req.wdata[0], 2);
    endproperty
    a_ctrl_s: assert property (p_ctrl_s) else $error("ctrl write lost");
    property p_aux_s;
        cw && !up_req.ns && sel == `SMAF_CFG_AUX
            |-> ##2 ns_lockdown_enabled == $past(up_req.wdata[26], 2);
    endproperty
    a_aux_s: assert property (p_aux_s) else $error("aux write lost");
    property p_pulse;
        up_rsp.valid |=> !up_rsp.valid && up_ready;
    endproperty
    a_pulse: assert property (p_pulse) else $error("long answer");
endmodule

bind smaf_top smaf_top_chk #(.LINES(LINES), .SECT_COUNT(SECT_COUNT)) u_smaf_top_chk (
    .clk(clk), .rst(rst), .up_req(up_req), .up_ready(up_ready), .up_rsp(up_rsp),
    .mem_req(mem_req), .mem_ready(mem_ready), .mem_rsp(mem_rsp), .sect_load(sect_load),
    .sect_value(sect_value), .cache_enabled(cache_enabled),
    .ns_lockdown_enabled(ns_lockdown_enabled));

`default_nettype wire

// >>> smaf_mem_model.sv
// memory model: random stalls, optional ns errors
// assumes one request at a time; unwritten words read inverted
`default_nettype none

module smaf_mem_model (
    input  wire logic                        clk,
    input  wire logic                        rst,
    input  wire smaf_pkg::smaf_mem_req_type  mem_req,
    output logic                             mem_ready,
    output smaf_pkg::smaf_mem_rsp_type       mem_rsp,
    input  wire logic                        err_ns,
    output int                               rd_count
);
    timeunit 1ns;
    timeprecision 1ps;
    import smaf_pkg::*;
    smaf_word_type    mem [smaf_word_type];
    smaf_word_type    w;
    smaf_mem_rsp_type pend;
    int               wait_cnt;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            mem_ready <= 1'b0;
            mem_rsp <= '0;
            rd_count <= 0;
            wait_cnt = -1;
        end else begin
            mem_rsp.valid <= 1'b0;
            mem_rsp.rdata <= $urandom;
            if (wait_cnt == 0) begin
                mem_rsp <= pend;
                wait_cnt = -1;
            end else if (wait_cnt > 0) begin
                wait_cnt--;
            end
            if (mem_req.valid && mem_ready) begin
                w = mem.exists(mem_req.addr) ? mem[mem_req.addr] : ~mem_req.addr;
                pend = '{1'b1, (err_ns && mem_req.ns) ? 2'h3 : 2'h0, w};
                for (int b = 0; b < 4; b++) begin
                    if (mem_req.wstrb[b]) w[8*b+:8] = mem_req.wdata[8*b+:8];
                end
                if (mem_req.write) mem[mem_req.addr] = w;
                else rd_count <= rd_count + 1;
                wait_cnt = $urandom_range(0, 3);
                mem_ready <= 1'b0;
            end else begin
                mem_ready <= (wait_cnt < 0) && ($urandom_range(0, 2) != 0);
            end
        end
    end
endmodule

`default_nettype wire

// >>> tb.sv
// bench for the filter
// assumes default smaf_top and the memory model
`include "smaf_defs.svh"
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import smaf_pkg::*;
    logic             clk, rst, mem_ready, sect_load, err_ns, up_ready;
    logic             cache_enabled, ns_lockdown_enabled;
    logic [31:0]      sect_value, sect;
    smaf_up_req_type  up_req;
    smaf_up_rsp_type  up_rsp;
    smaf_mem_req_type mem_req;
    smaf_mem_rsp_type mem_rsp;
    smaf_resp_type    r;
    smaf_word_type    d, a;
    smaf_word_type    shadow [smaf_word_type];
    int               rd_count, num_errors, compares, cycles, n;

    smaf_top u_smaf_top (.clk(clk), .rst(rst), .up_req(up_req),
        .up_ready(up_ready), .up_rsp(up_rsp), .mem_req(mem_req), .mem_ready(mem_ready),
        .mem_rsp(mem_rsp), .sect_load(sect_load), .sect_value(sect_value),
        .cache_enabled(cache_enabled), .ns_lockdown_enabled(ns_lockdown_enabled));
    smaf_mem_model u_smaf_mem_model (.clk(clk), .rst(rst), .mem_req(mem_req),
        .mem_ready(mem_ready), .mem_rsp(mem_rsp), .err_ns(err_ns), .rd_count(rd_count));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles > 30000) begin
            num_errors++;
            summarize();
        end
    end

    task automatic summarize();
        if (num_errors == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check(string name, logic [63:0] seen, logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    function automatic logic blk(logic ns, smaf_word_type ad);
        return ns && (ad[31] || !sect[ad[30:26]]);
    endfunction
    function automatic smaf_word_type expv(smaf_word_type ad);
        return shadow.exists(ad) ? shadow[ad] : ~ad;
    endfunction
    task automatic req(smaf_op_type op, logic ns, smaf_word_type ad, smaf_word_type w = '0);
        int k;
        k = 0;
        up_req = '{1'b1, op, ns, ad, w};
        while (up_ready !== 1'b1) @(negedge clk);
        @(negedge clk);
        up_req.valid = 1'b0;
        while (up_rsp.valid !== 1'b1 && k < 200) begin
            @(negedge clk);
            k++;
        end
        check("answer", up_rsp.valid, 1'b1);
        r = up_rsp.resp;
        d = up_rsp.rdata;
        @(negedge clk);
    endtask
    task automatic load_sect(logic [31:0] v);
        sect_value = v;
        sect_load = 1'b1;
        @(negedge clk);
        sect_load = 1'b0;
        sect = v;
        req(SMAF_OP_INV_ALL, 0, 32'h0);
    endtask
    task automatic rnd_access();
        smaf_word_type ad, w;
        logic          ns, wr, b;
        ad = {6'($urandom_range(0, 63)), 20'h0, 4'($urandom), 2'b00};
        w = $urandom;
        ns = 1'($urandom);
        wr = 1'($urandom);
        b = blk(ns, ad);
        req(wr ? SMAF_OP_WRITE : SMAF_OP_READ, ns, ad, w);
        check("resp", r, b ? `SMAF_RESP_DECERR : `SMAF_RESP_OKAY);
        if (!wr) check("rdata", d, b ? 32'h0 : expv(ad));
        else if (!b) shadow[ad] = w;
    endtask

    initial begin
        rst = 1'b1;
        up_req = '0;
        sect_load = 1'b0;
        sect_value = '0;
        sect = '0;
        err_ns = 1'b0;
        void'($urandom(63524));
        repeat (8) @(negedge clk);
        rst = 1'b0;
        req(SMAF_OP_READ, 1, 32'h0400_0010);
        check("rst sect", r, `SMAF_RESP_DECERR);
        req(SMAF_OP_CFG_WR, 0, 32'h0, 32'h1);
        check("cache on", cache_enabled, 1'b1);
        req(SMAF_OP_CFG_WR, 1, 32'h0);
        check("cache ns", cache_enabled, 1'b1);
        req(SMAF_OP_CFG_WR, 0, 32'h4, 32'h0400_0000);
        req(SMAF_OP_CFG_WR, 1, 32'h4);
        check("lockdown", ns_lockdown_enabled, 1'b1);
        req(SMAF_OP_CFG_WR, 1, 32'h8, 32'h5a);
        req(SMAF_OP_CFG_WR, 0, 32'h4);
        req(SMAF_OP_CFG_WR, 1, 32'h8, 32'h33);
        req(SMAF_OP_CFG_RD, 1, 32'h8);
        check("lock reg", d, 32'h5a);
        for (int i = 0; i < 2; i++) begin
            req(i ? SMAF_OP_CFG_WR : SMAF_OP_CFG_RD, 1, 32'hc, 32'h1);
            check("debug ns", r, `SMAF_RESP_DECERR);
        end
        req(SMAF_OP_CFG_RD, 0, 32'hc);
        check("debug s", r, `SMAF_RESP_OKAY);
        load_sect(32'h1);
        a = 32'h0000_0040;
        req(SMAF_OP_WRITE, 0, a, 32'hc0de_0001);
        shadow[a] = 32'hc0de_0001;
        req(SMAF_OP_READ, 0, a);
        n = rd_count;
        req(SMAF_OP_READ, 0, a);
        check("s hit", rd_count, n);
        err_ns = 1'b1;
        req(SMAF_OP_READ, 1, a);
        check("ns err", r, `SMAF_RESP_DECERR);
        err_ns = 1'b0;
        req(SMAF_OP_READ, 1, a);
        check("ns fill", rd_count, n + 2);
        check("ns data", d, 32'hc0de_0001);
        req(SMAF_OP_INV, 1, a);
        req(SMAF_OP_INV_ALL, 1, 32'h0);
        req(SMAF_OP_READ, 0, a);
        check("s kept", rd_count, n + 2);
        req(SMAF_OP_INV, 0, a);
        req(SMAF_OP_READ, 0, a);
        check("s inv", rd_count, n + 3);
        for (int k = 0; k < 6; k++) begin
            load_sect(k == 0 ? 32'hffff_ffff : $urandom);
            repeat (40) rnd_access();
        end
        rst = 1'b1;
        @(negedge clk);
        rst = 1'b0;
        sect = '0;
        check("cache reset", cache_enabled, 1'b0);
        req(SMAF_OP_READ, 1, 32'h0400_0000);
        check("rst again", r, `SMAF_RESP_DECERR);
        summarize();
    end
endmodule

`default_nettype wire
